// >>> led_fault_pkg.sv
package led_fault_pkg;

    localparam int REF_CLK_MHZ   = 100;
    localparam int LED_COUNT     = 72;
    localparam int ROW_COUNT     = 4;
    localparam int COL_COUNT     = 18;
    localparam int FAULT_BYTES   = 12;
    localparam int FAULT_BITS    = FAULT_BYTES * 8;

    // One scan cycle: four rows, each of on time plus both non-overlap gaps
    localparam int ROW_ON_NS     = 33000;
    localparam int NOL1_NS       = 830;
    localparam int NOL2_NS       = 300;
    localparam int SCAN_CYCLE_NS = ROW_COUNT * (ROW_ON_NS + NOL1_NS + NOL2_NS);
    localparam int SCANS_TO_VALID = 2;
    localparam int DETECT_WAIT_CYCLES_DEF =
        (SCANS_TO_VALID * SCAN_CYCLE_NS * REF_CLK_MHZ + 999) / 1000;

    localparam logic [6:0] DOT_FIRST_ADDR   = 7'h01;
    localparam logic [6:0] DOT_LAST_ADDR    = 7'h48;
    localparam logic [6:0] CONFIG_ADDR      = 7'h50;
    localparam logic [6:0] GCL_ADDR         = 7'h51;
    localparam logic [6:0] PULL_ADDR        = 7'h52;
    localparam logic [6:0] FAULT_FIRST_ADDR = 7'h53;
    localparam logic [6:0] FAULT_LAST_ADDR  = 7'h5e;

    localparam int SOFT_SHUTDOWN_BIT = 0;
    localparam int DETECT_SEL_LSB    = 1;
    localparam int COL_PULL_LSB      = 0;
    localparam int ROW_PULL_LSB      = 4;

    localparam logic [1:0] DETECT_OFF   = 2'h0;
    localparam logic [1:0] DETECT_OPEN  = 2'h1;
    localparam logic [1:0] DETECT_SHORT = 2'h2;

    localparam logic [7:0] DOT_RESET    = 8'h00;
    localparam logic [7:0] CONFIG_RESET = 8'h00;
    localparam logic [7:0] GCL_RESET    = 8'h00;
    localparam logic [7:0] PULL_RESET   = 8'h00;
    localparam logic [7:0] IDLE_READ    = 8'hff;

    // Serial frame: command byte, then data byte (write) or dummy + data
    localparam logic [4:0] CMD_LAST_BIT  = 5'h07;
    localparam logic [4:0] DATA_LAST_BIT = 5'h0f;
    localparam logic [4:0] BIT_CNT_MAX   = 5'h1f;

    typedef struct packed {
        logic [6:0] addr;
        logic [7:0] data;
    } serial_req_type;

    typedef enum logic {DETECT_IDLE, DETECT_WAIT} detect_state_type;

endpackage

// >>> serial_link.sv
`timescale 1ns/1ps
module serial_link (
    input  wire logic                        sck,
    input  wire logic                        rst,
    input  wire logic                        serialReset,
    input  wire logic                        csN,
    input  wire logic                        mosi,
    input  wire logic                        rdAckTgl,
    input  wire logic [7:0]                  rdData,
    output logic                             misoOut,
    output logic                             misoOeN,
    output logic                             wrTgl,
    output logic                             rdTgl,
    output led_fault_pkg::serial_req_type    req
);

    logic                          frameClr;
    logic [4:0]                    bitCnt_reg, bitCnt_next;
    logic [7:0]                    shift_reg, shift_next;
    logic                          isRead_reg, isRead_next;
    logic [7:0]                    txShift_reg, txShift_next;
    logic                          misoBit_reg;
    led_fault_pkg::serial_req_type req_reg, req_next;
    logic                          wrTgl_reg, wrTgl_next;
    logic                          rdTgl_reg, rdTgl_next;
    logic                          ackSync1_reg, ackSync2_reg;
    logic [7:0]                    shiftIn;

    // Frame state ends with chip select or a shutdown-pin release
    assign frameClr = rst | csN | serialReset;
    assign shiftIn  = {shift_reg[6:0], mosi};

    always_comb begin
        bitCnt_next  = (bitCnt_reg == led_fault_pkg::BIT_CNT_MAX) ?
                       bitCnt_reg : 5'(bitCnt_reg + 5'h01);
        shift_next   = shiftIn;
        isRead_next  = isRead_reg;
        txShift_next = {txShift_reg[6:0], 1'b1};
        req_next     = req_reg;
        wrTgl_next   = wrTgl_reg;
        rdTgl_next   = rdTgl_reg;
        if (bitCnt_reg == led_fault_pkg::CMD_LAST_BIT) begin
            isRead_next   = shiftIn[7];
            req_next.addr = shiftIn[6:0];
            if (shiftIn[7]) begin
                rdTgl_next = ~rdTgl_reg;
            end
        end
        if (bitCnt_reg == led_fault_pkg::DATA_LAST_BIT) begin
            if (isRead_reg) begin
                // Answer not back yet reads as all ones rather than stale data
                txShift_next = (ackSync2_reg == rdTgl_reg) ?
                               rdData : led_fault_pkg::IDLE_READ;
            end else begin
                req_next.data = shiftIn;
                wrTgl_next    = ~wrTgl_reg;
            end
        end
    end

    always_ff @(posedge sck or posedge frameClr) begin
        if (frameClr) begin
            bitCnt_reg  <= 5'h00;
            shift_reg   <= 8'h00;
            isRead_reg  <= 1'b0;
            txShift_reg <= led_fault_pkg::IDLE_READ;
        end else begin
            bitCnt_reg  <= bitCnt_next;
            shift_reg   <= shift_next;
            isRead_reg  <= isRead_next;
            txShift_reg <= txShift_next;
        end
    end

    // Toggles survive frame ends so the far side never sees a false event
    always_ff @(posedge sck or posedge rst) begin
        if (rst) begin
            req_reg      <= '0;
            wrTgl_reg    <= 1'b0;
            rdTgl_reg    <= 1'b0;
            ackSync1_reg <= 1'b0;
            ackSync2_reg <= 1'b0;
        end else begin
            req_reg      <= req_next;
            wrTgl_reg    <= wrTgl_next;
            rdTgl_reg    <= rdTgl_next;
            ackSync1_reg <= rdAckTgl;
            ackSync2_reg <= ackSync1_reg;
        end
    end

    always_ff @(negedge sck or posedge frameClr) begin
        if (frameClr) begin
            misoBit_reg <= 1'b1;
        end else begin
            misoBit_reg <= txShift_reg[7];
        end
    end

    assign misoOut = misoBit_reg;
    assign misoOeN = csN;
    assign wrTgl   = wrTgl_reg;
    assign rdTgl   = rdTgl_reg;
    assign req     = req_reg;

endmodule

// >>> led_fault_ctrl.sv
`timescale 1ns/1ps
module led_fault_ctrl #(
    parameter int DETECT_WAIT_CYCLES = led_fault_pkg::DETECT_WAIT_CYCLES_DEF
) (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        sck,
    input  wire logic        csN,
    input  wire logic        mosi,
    output logic             misoOut,
    output logic             misoOeN,
    input  wire logic        shutdownPinN,
    input  wire logic [3:0]  scanRowOn,
    input  wire logic [17:0] scanColOn,
    input  wire logic [71:0] openSense,
    input  wire logic [71:0] shortSense,
    output logic [3:0]       rowSwitchOutputs,
    output logic [17:0]      columnSinkOutputs,
    output logic [3:0]       rowPullEnable,
    output logic [17:0]      columnPullEnable,
    output logic             analogEnable,
    output logic             detectBusy,
    output logic             faultValid
);

    localparam int          NLED      = led_fault_pkg::LED_COUNT;
    localparam int          NFAULT    = led_fault_pkg::FAULT_BITS;
    localparam logic [15:0] WAIT_LAST = 16'(DETECT_WAIT_CYCLES - 1);

    led_fault_pkg::serial_req_type   linkReq;
    logic                            wrTgl, rdTgl;

    logic [7:0]  dotScale_reg [NLED];
    logic [7:0]  dotScale_next [NLED];
    logic [7:0]  config_reg, config_next;
    logic [7:0]  gcl_reg, gcl_next;
    logic [7:0]  pull_reg, pull_next;
    logic [NFAULT-1:0] faultStatus_reg, faultStatus_next;
    logic        faultValid_reg, faultValid_next;
    led_fault_pkg::detect_state_type state_reg, state_next;
    logic [15:0] waitCnt_reg, waitCnt_next;
    logic [1:0]  mode_reg, mode_next;

    logic        wrSync1_reg, wrSync2_reg, wrSeen_reg;
    logic        rdSync1_reg, rdSync2_reg, rdSeen_reg;
    logic        sdbSync1_reg, sdbSync2_reg, sdbPrev_reg;
    logic [71:0] openSync1_reg, openSync2_reg;
    logic [71:0] shortSync1_reg, shortSync2_reg;

    logic [7:0]  rdData_reg, rdData_next;
    logic        rdAck_reg, rdAck_next;
    logic        serialReset_reg, serialReset_next;

    logic [3:0]  rowSw_reg, rowSw_next, rowPull_reg, rowPull_next;
    logic [17:0] colSink_reg, colSink_next, colPull_reg, colPull_next;
    logic        analogEn_reg, analogEn_next;

    logic        wrEvent, rdEvent, cfgWrite, startDetect, captureNow;
    logic [1:0]  oldSel, newSel;
    logic [6:0]  dotIdx, rdIdx;
    logic [7:0]  readMux;

    serial_link u_link (
        .sck         (sck),
        .rst         (rst),
        .serialReset (serialReset_reg),
        .csN         (csN),
        .mosi        (mosi),
        .rdAckTgl    (rdAck_reg),
        .rdData      (rdData_reg),
        .misoOut     (misoOut),
        .misoOeN     (misoOeN),
        .wrTgl       (wrTgl),
        .rdTgl       (rdTgl),
        .req         (linkReq)
    );

    // Synchronisers for link toggles, the shutdown pin and analog comparators
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wrSync1_reg    <= 1'b0;
            wrSync2_reg    <= 1'b0;
            wrSeen_reg     <= 1'b0;
            rdSync1_reg    <= 1'b0;
            rdSync2_reg    <= 1'b0;
            rdSeen_reg     <= 1'b0;
            // Pin idles high, so leaving reset must not look like a rise
            sdbSync1_reg   <= 1'b1;
            sdbSync2_reg   <= 1'b1;
            sdbPrev_reg    <= 1'b1;
            openSync1_reg  <= '0;
            openSync2_reg  <= '0;
            shortSync1_reg <= '0;
            shortSync2_reg <= '0;
        end else begin
            wrSync1_reg    <= wrTgl;
            wrSync2_reg    <= wrSync1_reg;
            wrSeen_reg     <= wrSync2_reg;
            rdSync1_reg    <= rdTgl;
            rdSync2_reg    <= rdSync1_reg;
            rdSeen_reg     <= rdSync2_reg;
            sdbSync1_reg   <= shutdownPinN;
            sdbSync2_reg   <= sdbSync1_reg;
            sdbPrev_reg    <= sdbSync2_reg;
            openSync1_reg  <= openSense;
            openSync2_reg  <= openSync1_reg;
            shortSync1_reg <= shortSense;
            shortSync2_reg <= shortSync1_reg;
        end
    end

    // Address and data from the link are stable once the toggle is seen here
    assign wrEvent     = wrSync2_reg != wrSeen_reg;
    assign rdEvent     = rdSync2_reg != rdSeen_reg;
    assign cfgWrite    = wrEvent && linkReq.addr == led_fault_pkg::CONFIG_ADDR;
    assign oldSel      = config_reg[led_fault_pkg::DETECT_SEL_LSB +: 2];
    assign newSel      = linkReq.data[led_fault_pkg::DETECT_SEL_LSB +: 2];
    assign startDetect = cfgWrite &&
                         oldSel == led_fault_pkg::DETECT_OFF &&
                         (newSel == led_fault_pkg::DETECT_OPEN ||
                          newSel == led_fault_pkg::DETECT_SHORT);
    assign captureNow  = state_reg == led_fault_pkg::DETECT_WAIT &&
                         waitCnt_reg == WAIT_LAST;
    assign dotIdx      = 7'(linkReq.addr - led_fault_pkg::DOT_FIRST_ADDR);

    // Register writes take effect regardless of either shutdown
    always_comb begin
        dotScale_next = dotScale_reg;
        config_next   = config_reg;
        gcl_next      = gcl_reg;
        pull_next     = pull_reg;
        if (wrEvent) begin
            if (linkReq.addr >= led_fault_pkg::DOT_FIRST_ADDR &&
                linkReq.addr <= led_fault_pkg::DOT_LAST_ADDR) begin
                dotScale_next[dotIdx] = linkReq.data;
            end else if (linkReq.addr == led_fault_pkg::CONFIG_ADDR) begin
                config_next = linkReq.data;
            end else if (linkReq.addr == led_fault_pkg::GCL_ADDR) begin
                gcl_next = linkReq.data;
            end else if (linkReq.addr == led_fault_pkg::PULL_ADDR) begin
                pull_next = linkReq.data;
            end
            // Fault status offsets fall through: no write path exists
        end
    end

    // No shutdown term reaches these registers, so contents persist
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NLED; i++) begin
                dotScale_reg[i] <= led_fault_pkg::DOT_RESET;
            end
            config_reg <= led_fault_pkg::CONFIG_RESET;
            gcl_reg    <= led_fault_pkg::GCL_RESET;
            pull_reg   <= led_fault_pkg::PULL_RESET;
        end else begin
            dotScale_reg <= dotScale_next;
            config_reg   <= config_next;
            gcl_reg      <= gcl_next;
            pull_reg     <= pull_next;
        end
    end

    // A new clear-then-set arming restarts the wait; anything else runs on
    always_comb begin
        state_next      = state_reg;
        waitCnt_next    = waitCnt_reg;
        mode_next       = mode_reg;
        faultValid_next = faultValid_reg;
        if (startDetect) begin
            state_next      = led_fault_pkg::DETECT_WAIT;
            waitCnt_next    = 16'h0000;
            mode_next       = newSel;
            faultValid_next = 1'b0;
        end else begin
            unique case (state_reg)
                led_fault_pkg::DETECT_IDLE: begin
                    waitCnt_next = 16'h0000;
                end
                led_fault_pkg::DETECT_WAIT: begin
                    if (captureNow) begin
                        state_next      = led_fault_pkg::DETECT_IDLE;
                        faultValid_next = 1'b1;
                    end else begin
                        waitCnt_next = 16'(waitCnt_reg + 16'h0001);
                    end
                end
            endcase
        end
    end

    generate
        for (genvar g = 0; g < NLED; g++) begin : g_capture
            // Dark dots cannot be sensed, so their old result stands
            assign faultStatus_next[g] =
                (captureNow && dotScale_reg[g] != 8'h00) ?
                ((mode_reg == led_fault_pkg::DETECT_OPEN) ?
                 openSync2_reg[g] : shortSync2_reg[g]) :
                faultStatus_reg[g];
        end
    endgenerate
    assign faultStatus_next[NFAULT-1:NLED] = faultStatus_reg[NFAULT-1:NLED];

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_reg       <= led_fault_pkg::DETECT_IDLE;
            waitCnt_reg     <= 16'h0000;
            mode_reg        <= led_fault_pkg::DETECT_OFF;
            faultValid_reg  <= 1'b0;
            faultStatus_reg <= '0;
        end else begin
            state_reg       <= state_next;
            waitCnt_reg     <= waitCnt_next;
            mode_reg        <= mode_next;
            faultValid_reg  <= faultValid_next;
            faultStatus_reg <= faultStatus_next;
        end
    end

    // Read answer is captured once per request and held for the link
    always_comb begin
        rdIdx   = 7'(linkReq.addr - led_fault_pkg::DOT_FIRST_ADDR);
        readMux = 8'h00;
        if (linkReq.addr >= led_fault_pkg::DOT_FIRST_ADDR &&
            linkReq.addr <= led_fault_pkg::DOT_LAST_ADDR) begin
            readMux = dotScale_reg[rdIdx];
        end else if (linkReq.addr == led_fault_pkg::CONFIG_ADDR) begin
            readMux = config_reg;
        end else if (linkReq.addr == led_fault_pkg::GCL_ADDR) begin
            readMux = gcl_reg;
        end else if (linkReq.addr == led_fault_pkg::PULL_ADDR) begin
            readMux = pull_reg;
        end else if (linkReq.addr >= led_fault_pkg::FAULT_FIRST_ADDR &&
                     linkReq.addr <= led_fault_pkg::FAULT_LAST_ADDR) begin
            rdIdx   = 7'(linkReq.addr - led_fault_pkg::FAULT_FIRST_ADDR);
            readMux = faultStatus_reg[8 * rdIdx +: 8];
        end
        rdData_next      = rdEvent ? readMux : rdData_reg;
        rdAck_next       = rdEvent ? ~rdAck_reg : rdAck_reg;
        serialReset_next = sdbSync2_reg && !sdbPrev_reg;
    end

    // Pulls are gated by the same next values as the outputs they shadow,
    // so a pull and its output are never on in the same cycle
    always_comb begin
        analogEn_next = sdbSync2_reg;
        rowSw_next    = scanRowOn & {4{sdbSync2_reg}};
        colSink_next  = scanColOn &
            {18{sdbSync2_reg & config_reg[led_fault_pkg::SOFT_SHUTDOWN_BIT]}};
        rowPull_next  = ~rowSw_next & {4{sdbSync2_reg &&
            pull_reg[led_fault_pkg::ROW_PULL_LSB +: 3] != 3'h0}};
        colPull_next  = ~colSink_next & {18{sdbSync2_reg &&
            pull_reg[led_fault_pkg::COL_PULL_LSB +: 3] != 3'h0}};
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdData_reg      <= 8'h00;
            rdAck_reg       <= 1'b0;
            serialReset_reg <= 1'b0;
            analogEn_reg    <= 1'b0;
            rowSw_reg       <= 4'h0;
            colSink_reg     <= 18'h00000;
            rowPull_reg     <= 4'h0;
            colPull_reg     <= 18'h00000;
        end else begin
            rdData_reg      <= rdData_next;
            rdAck_reg       <= rdAck_next;
            serialReset_reg <= serialReset_next;
            analogEn_reg    <= analogEn_next;
            rowSw_reg       <= rowSw_next;
            colSink_reg     <= colSink_next;
            rowPull_reg     <= rowPull_next;
            colPull_reg     <= colPull_next;
        end
    end

    assign rowSwitchOutputs  = rowSw_reg;
    assign columnSinkOutputs = colSink_reg;
    assign rowPullEnable     = rowPull_reg;
    assign columnPullEnable  = colPull_reg;
    assign analogEnable      = analogEn_reg;
    assign detectBusy        = state_reg == led_fault_pkg::DETECT_WAIT;
    assign faultValid        = faultValid_reg;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    arm_start_a: assert property (startDetect |=> detectBusy &&
        waitCnt_reg == 16'h0000) else $error("arming did not start capture");
    fault_wait_a: assert property ($changed(faultStatus_reg) |->
        $past(captureNow)) else $error("fault status changed outside capture");
    dark_dot_a: assert property (
        (captureNow && dotScale_reg[0] == 8'h00) |=>
        $stable(faultStatus_reg[0])) else $error("dark dot refreshed");
    pull_off_a: assert property ((pull_reg == 8'h00) |=>
        rowPullEnable == 4'h0 && columnPullEnable == 18'h00000)
        else $error("pull active with select cleared");
    no_retrigger_a: assert property (
        (cfgWrite && oldSel != led_fault_pkg::DETECT_OFF && !detectBusy) |=>
        !detectBusy) else $error("capture retriggered");
    pull_when_off_a: assert property (
        (columnPullEnable & columnSinkOutputs) == 18'h00000 &&
        (rowPullEnable & rowSwitchOutputs) == 4'h0)
        else $error("pull on while output on");
    serial_reset_a: assert property (
        (sdbSync2_reg && !sdbPrev_reg) |=>
        serialReset_reg ##1 !serialReset_reg)
        else $error("serial reset not one cycle on pin rise");
    regs_hold_a: assert property (
        (!sdbSync2_reg && !wrEvent) |=>
        $stable(gcl_reg) && $stable(config_reg))
        else $error("register lost in shutdown");
    soft_blank_a: assert property (
        !config_reg[led_fault_pkg::SOFT_SHUTDOWN_BIT] |=>
        columnSinkOutputs == 18'h00000) else $error("sinks on in soft shutdown");
    hw_shutdown_a: assert property (!sdbSync2_reg |=>
        !analogEnable && columnSinkOutputs == 18'h00000)
        else $error("analog on in hardware shutdown");
    hw_write_a: assert property ((!sdbSync2_reg && wrEvent &&
        linkReq.addr == led_fault_pkg::GCL_ADDR) |=>
        gcl_reg == $past(linkReq.data)) else $error("write lost in shutdown");
    fault_ro_a: assert property ((wrEvent && !captureNow &&
        linkReq.addr >= led_fault_pkg::FAULT_FIRST_ADDR &&
        linkReq.addr <= led_fault_pkg::FAULT_LAST_ADDR) |=>
        $stable(faultStatus_reg)) else $error("fault status written");
    valid_hold_a: assert property (
        (faultValid && !startDetect) |=> faultValid)
        else $error("fault valid dropped without re-arm");
    busy_bound_a: assert property (
        detectBusy |-> waitCnt_reg <= WAIT_LAST)
        else $error("capture wait overran");
    analog_on_a: assert property (
        sdbSync2_reg |=> analogEnable)
        else $error("analog off with pin high");
    rows_follow_a: assert property (
        sdbSync2_reg |=> rowSwitchOutputs == $past(scanRowOn))
        else $error("row switches gated by soft shutdown");

    arm_c: cover property (startDetect);
    capture_c: cover property (captureNow ##1 faultValid);
    pin_rise_c: cover property (serialReset_reg);
    soft_off_c: cover property (cfgWrite &&
        !linkReq.data[led_fault_pkg::SOFT_SHUTDOWN_BIT]);
    short_mode_c: cover property (startDetect &&
        newSel == led_fault_pkg::DETECT_SHORT);

endmodule

// >>> host_spi.sv
`timescale 1ns/1ps
module host_spi (
    output logic      sck,
    output logic      csN,
    output logic      mosi,
    input  wire logic miso
);
    initial begin
        sck = 1'b0;
        csN = 1'b1;
        mosi = 1'b0;
    end
    // Clock runs only inside frames; idle mosi flips so it never looks held
    task automatic xfer(input logic [23:0] f, input int n, input bit keep,
                        output logic [7:0] r);
        csN = 1'b0;
        for (int i = 0; i < n; i++) begin
            mosi = f[23-i];
            #24;
            sck = 1'b1;
            if (i >= 16) r = {r[6:0], miso};
            #24;
            sck = 1'b0;
        end
        #24;
        if (!keep) csN = 1'b1;
        mosi = ~mosi;
        #100;
    endtask
endmodule

// >>> testbench.sv
`timescale 1ns/1ps
module testbench;
    logic        ref_clk, rst, sck, csN, mosi, misoOut, misoOeN, pinN;
    logic [3:0]  rowOn, rowSw, rowPull;
    logic [17:0] colOn, colSink, colPull;
    logic [71:0] openS, shortS;
    logic        anaEn, busy, valid;
    logic [7:0]  r;
    int          errors, n_compared;
    led_fault_ctrl #(.DETECT_WAIT_CYCLES(20)) dut (.ref_clk(ref_clk),
        .rst(rst), .sck(sck), .csN(csN), .mosi(mosi), .misoOut(misoOut),
        .misoOeN(misoOeN), .shutdownPinN(pinN), .scanRowOn(rowOn),
        .scanColOn(colOn), .openSense(openS), .shortSense(shortS),
        .rowSwitchOutputs(rowSw), .columnSinkOutputs(colSink),
        .rowPullEnable(rowPull), .columnPullEnable(colPull),
        .analogEnable(anaEn), .detectBusy(busy), .faultValid(valid));
    host_spi host (.sck(sck), .csN(csN), .mosi(mosi), .miso(misoOut));
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic chk(input logic [17:0] got, input logic [17:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        host.xfer({1'b0, a, d, 8'h00}, 16, 1'b0, r);
    endtask
    task automatic rdchk(input logic [6:0] a, input logic [7:0] e);
        host.xfer({1'b1, a, 16'h0000}, 24, 1'b0, r);
        chk({10'h000, r}, {10'h000, e});
    endtask
    task automatic wait_valid;
        for (int i = 0; i < 60 && valid !== 1'b1; i++) cyc(1);
        chk({17'h0, valid}, 18'h1);
    endtask
    task automatic t_pulls;
        wr(7'h52, 8'h11);
        wr(7'h50, 8'h01);
        cyc(5);
        chk({14'h0, rowPull}, 18'hf);
        rowOn = 4'h5;
        colOn = 18'h00f0f;
        cyc(5);
        chk({14'h0, rowPull}, 18'ha);
        chk(colPull, 18'h3f0f0);
        wr(7'h50, 8'h00);
        cyc(5);
        chk(colSink, 18'h0);
        chk(colPull, 18'h3ffff);
        wr(7'h52, 8'h00);
        cyc(5);
        chk(colPull, 18'h0);
        chk({14'h0, rowPull}, 18'h0);
        $display("test pulls done");
    endtask
    task automatic t_soft;
        colOn = 18'h3ffff;
        cyc(5);
        chk(colSink, 18'h0);
        wr(7'h50, 8'h01);
        cyc(5);
        chk(colSink, 18'h3ffff);
        chk({14'h0, rowSw}, 18'h5);
        rdchk(7'h50, 8'h01);
        $display("test soft shutdown done");
    endtask
    task automatic t_detect;
        wr(7'h51, 8'h20);
        wr(7'h01, 8'hff);
        wr(7'h50, 8'h03);
        chk({16'h0, busy, valid}, 18'h2);
        wait_valid();
        rdchk(7'h53, 8'h01);
        wr(7'h53, 8'hff);
        rdchk(7'h53, 8'h01);
        openS = '0;
        wr(7'h50, 8'h03);
        cyc(30);
        chk({17'h0, valid}, 18'h1);
        rdchk(7'h53, 8'h01);
        wr(7'h01, 8'h00);
        wr(7'h02, 8'hff);
        shortS = 72'h2;
        wr(7'h50, 8'h01);
        wr(7'h50, 8'h05);
        wait_valid();
        rdchk(7'h53, 8'h03);
        $display("test detect done");
    endtask
    task automatic t_hw;
        pinN = 1'b0;
        cyc(5);
        chk({9'h0, anaEn, rowSw, rowPull}, 18'h0);
        chk(colSink, 18'h0);
        wr(7'h51, 8'h33);
        rdchk(7'h51, 8'h33);
        rdchk(7'h50, 8'h05);
        host.xfer(24'hffffff, 4, 1'b1, r);
        pinN = 1'b1;
        cyc(10);
        rdchk(7'h51, 8'h33);
        chk({17'h0, anaEn}, 18'h1);
        chk(colSink, 18'h3ffff);
        $display("test hardware shutdown done");
    endtask
    task automatic complete_run;
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        #400000;
        errors++;
        complete_run();
    end
    initial begin
        errors = 0;
        n_compared = 0;
        rst = 1'b1;
        pinN = 1'b1;
        rowOn = 4'h0;
        colOn = 18'h0;
        openS = '1;
        shortS = '0;
        cyc(8);
        rst = 1'b0;
        cyc(2);
        rdchk(7'h50, 8'h00);
        rdchk(7'h52, 8'h00);
        chk({17'h0, misoOeN}, 18'h1);
        t_pulls();
        t_soft();
        t_detect();
        t_hw();
        complete_run();
    end
endmodule
